// file: core/dwsc_pkg.sv
// Shared constants and types of the dual wiper serial control block.
package dwsc_pkg;
    localparam int WORD_W = 16;
    localparam int CMD_MSB = 15;
    localparam int CMD_LSB = 12;
    localparam int ADDR_MSB = 11;
    localparam int ADDR_LSB = 8;
    localparam int SEL_POS = 8;
    localparam int DATA_MSB = 7;
    localparam int DATA_LSB = 0;
    localparam int CHANNELS = 2;
    localparam int NV_WORDS = 16;
    localparam int BITCNT_W = 5;
    localparam logic [BITCNT_W-1:0] BITCNT_MAX = 5'h1f;
    localparam logic [7:0] MIDSCALE = 8'h80;
    localparam int SAVE_TIME_MS = 25;
    localparam int CLK_HZ = 100_000_000;
    localparam int SAVE_CYCLES = SAVE_TIME_MS * (CLK_HZ / 1000);
    localparam int PROG_CNT_W = 24;

    typedef enum logic [3:0] {
        CMD_NOP = 4'h0,
        CMD_RESTORE_ONE = 4'h1,
        CMD_SAVE = 4'h2,
        CMD_STORE_USER = 4'h3,
        CMD_SHR_ONE = 4'h4,
        CMD_SHR_ALL = 4'h5,
        CMD_DEC_ONE = 4'h6,
        CMD_DEC_ALL = 4'h7,
        CMD_RESTORE_ALL = 4'h8,
        CMD_READ_NV = 4'h9,
        CMD_READ_WIPER = 4'ha,
        CMD_WRITE_WIPER = 4'hb,
        CMD_SHL_ONE = 4'hc,
        CMD_SHL_ALL = 4'hd,
        CMD_INC_ONE = 4'he,
        CMD_INC_ALL = 4'hf
    } dwsc_cmd_type;

    typedef enum logic [2:0] {
        ST_LOAD = 3'h1,
        ST_IDLE = 3'h2,
        ST_PROG = 3'h4
    } dwsc_state_type;
endpackage : dwsc_pkg

// file: core/dwsc_link_if.sv
// Signals passed between the serial link logic and the core logic.
interface dwsc_link_if;
    logic [15:0] rx_word;
    logic frame_tgl;
    logic rb_en;
    logic [7:0] rb_byte;
    modport link(output rx_word, output frame_tgl,
                 input rb_en, input rb_byte);
    modport core(input rx_word, input frame_tgl,
                 output rb_en, output rb_byte);
endinterface : dwsc_link_if

// file: core/dwsc_link.sv
// Serial shift register and data output, clocked by the serial clock.
module dwsc_link
    import dwsc_pkg::*;
(
    input wire logic i_sys_rst,
    input wire logic i_sclk,
    input wire logic i_sdi,
    input wire logic i_cs_n,
    output logic o_sdo_oe_n,
    dwsc_link_if.link lnk
);
    typedef struct packed {
        logic [WORD_W-1:0] rx_sr;
        logic frame_tgl;
    } dwsc_link_type;

    dwsc_link_type link_reg;
    dwsc_link_type link_next;
    logic [BITCNT_W-1:0] bit_cnt_reg;
    logic sdo_hold_reg;
    logic echo_bit;
    logic sdo_bit;

    // The bit counter belongs to one frame, so the frame's own select
    // clears it; the serial clock may stand still once select is high.
    always_ff @(posedge i_sclk or posedge i_cs_n or posedge i_sys_rst) begin
        if (i_cs_n || i_sys_rst) begin
            bit_cnt_reg <= '0;
        end else if (bit_cnt_reg != BITCNT_MAX) begin
            bit_cnt_reg <= bit_cnt_reg + 5'h01;
        end
    end

    always_comb begin
        link_next = link_reg;
        if (!i_cs_n) begin
            link_next.rx_sr = {link_reg.rx_sr[WORD_W-2:0], i_sdi};
            if (bit_cnt_reg == '0) begin
                link_next.frame_tgl = ~link_reg.frame_tgl;
            end
        end
    end

    always_ff @(posedge i_sclk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            link_reg <= '0;
        end else begin
            link_reg <= link_next;
        end
    end

    // Bits beyond the first word carry the input delayed by one word.
    always_comb begin
        echo_bit = link_reg.rx_sr[WORD_W-1];
        if (lnk.rb_en && bit_cnt_reg[4:3] == 2'h1) begin
            echo_bit = lnk.rb_byte[~bit_cnt_reg[2:0]];
        end
    end

    // Output changes on the falling edge so that the master can sample
    // it on the rising edge in either clock mode.
    always_ff @(negedge i_sclk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            sdo_hold_reg <= 1'b1;
        end else begin
            sdo_hold_reg <= echo_bit;
        end
    end

    assign sdo_bit = (bit_cnt_reg == '0) ? echo_bit : sdo_hold_reg;
    assign o_sdo_oe_n = i_cs_n | sdo_bit;
    assign lnk.rx_word = link_reg.rx_sr;
    assign lnk.frame_tgl = link_reg.frame_tgl;
endmodule : dwsc_link

// file: core/dwsc_top.sv
// Serial command slave of a dual channel digital potentiometer.

// Functional notes
// - Write-wiper command loads the data byte into the addressed wiper.
// - Save command copies the addressed wiper into its nonvolatile word.
// - A nonvolatile write takes the 25 ms program time.
// - After reset each wiper is loaded from its nonvolatile word.
// - Preset low forces midscale; its rising edge reloads from storage.
// - Each frame shifts out the word received in the frame before; after a read, its data byte holds the read value.
// - Increment, decrement and shift commands move a wiper by one or 2x.
// - A strobe with no new bits repeats the last command if that was a step command.
// - A frame is a 16-bit word shifted in most significant bit first.
// - The word is decoded and executed only when select goes high.
// - Command field picks the operation, address the target, data value.
// - Write protect low blocks command changes except restores and preset.
// - The open-drain serial output is released while select is high.
// - Link works in clock modes phase1/polarity1 and phase0/polarity0.
// - Read commands return the wiper or the nonvolatile word.
// - All other commands pass the shifted word through for chaining.
// - Word fields: 4-bit command, 4-bit address, 8-bit data.
// - Input commands are locked out while a nonvolatile write runs.
// - Ready output shows completion of store, power-up load and preset.
// - Nonvolatile wiper words hold midscale 80h until stored.
module dwsc_top
    import dwsc_pkg::*;
#(
    parameter int unsigned PROG_CYCLES = SAVE_CYCLES
)
(
    input wire logic i_clk,
    input wire logic i_sys_rst,
    input wire logic i_sclk,
    input wire logic i_sdi,
    input wire logic i_cs_n,
    input wire logic i_preset_n,
    input wire logic i_wp_n,
    output logic o_sdo_out,
    output logic o_sdo_oe_n,
    output logic o_rdy_out,
    output logic o_rdy_oe_n,
    output logic [7:0] o_wiper0,
    output logic [7:0] o_wiper1
);
    typedef struct packed {
        dwsc_state_type state;
        logic cs_s1;
        logic cs_s2;
        logic cs_prev;
        logic pr_s1;
        logic pr_s2;
        logic pr_prev;
        logic wp_s1;
        logic wp_s2;
        logic tg_s1;
        logic tg_s2;
        logic tg_seen;
        logic [CHANNELS-1:0][7:0] wiper_position_reg;
        logic [NV_WORDS-1:0][7:0] nonvolatile_store;
        logic rpt_valid;
        logic [3:0] rpt_cmd;
        logic rpt_sel;
        logic rb_en;
        logic [7:0] rb_byte;
        logic [PROG_CNT_W-1:0] prog_cnt;
    } dwsc_core_type;

    localparam dwsc_core_type CORE_RST = '{
        state: ST_LOAD,
        cs_s1: 1'b1,
        cs_s2: 1'b1,
        cs_prev: 1'b1,
        pr_s1: 1'b1,
        pr_s2: 1'b1,
        pr_prev: 1'b1,
        wp_s1: 1'b1,
        wp_s2: 1'b1,
        wiper_position_reg: {CHANNELS{MIDSCALE}},
        nonvolatile_store: {NV_WORDS{MIDSCALE}},
        default: '0
    };

    localparam logic [PROG_CNT_W-1:0] PROG_LOAD = PROG_CNT_W'(PROG_CYCLES);

    dwsc_core_type core_reg;
    dwsc_core_type core_next;

    dwsc_link_if lnk();

    dwsc_link u_link (
        .i_sys_rst(i_sys_rst),
        .i_sclk(i_sclk),
        .i_sdi(i_sdi),
        .i_cs_n(i_cs_n),
        .o_sdo_oe_n(o_sdo_oe_n),
        .lnk(lnk.link)
    );

    // New wiper value for a step command; both ends of the range hold.
    function automatic logic [7:0] step_value(
        input logic [3:0] op,
        input logic [7:0] w
    );
        logic [7:0] v;
        v = w;
        case (op[3:1])
            3'h2: v = {1'b0, w[7:1]};
            3'h3: v = (w == 8'h00) ? w : w - 8'h01;
            3'h6: v = w[7] ? 8'hff : {w[6:0], 1'b1};
            3'h7: v = (w == 8'hff) ? w : w + 8'h01;
            default: v = w;
        endcase
        return v;
    endfunction : step_value

    always_comb begin
        logic frame_end;
        logic new_data;
        logic do_exec;
        logic wp_free;
        logic [3:0] op;
        logic sel;
        logic [3:0] addr;
        logic [7:0] dat;
        frame_end = 1'b0;
        new_data = 1'b0;
        do_exec = 1'b0;
        wp_free = 1'b0;
        op = 4'h0;
        sel = 1'b0;
        addr = 4'h0;
        dat = 8'h00;
        core_next = core_reg;

        core_next.cs_s1 = i_cs_n;
        core_next.cs_s2 = core_reg.cs_s1;
        core_next.cs_prev = core_reg.cs_s2;
        core_next.pr_s1 = i_preset_n;
        core_next.pr_s2 = core_reg.pr_s1;
        core_next.pr_prev = core_reg.pr_s2;
        core_next.wp_s1 = i_wp_n;
        core_next.wp_s2 = core_reg.wp_s1;
        core_next.tg_s1 = lnk.frame_tgl;
        core_next.tg_s2 = core_reg.tg_s1;

        // The shift register is still while select is high, so the word
        // is read only after the synchronised rising edge of select.
        frame_end = core_reg.cs_s2 & ~core_reg.cs_prev;
        new_data = core_reg.tg_s2 != core_reg.tg_seen;
        wp_free = core_reg.wp_s2;
        if (frame_end) begin
            core_next.tg_seen = core_reg.tg_s2;
        end

        if (new_data) begin
            op = lnk.rx_word[CMD_MSB:CMD_LSB];
            sel = lnk.rx_word[SEL_POS];
            addr = lnk.rx_word[ADDR_MSB:ADDR_LSB];
            dat = lnk.rx_word[DATA_MSB:DATA_LSB];
        end else begin
            op = core_reg.rpt_cmd;
            sel = core_reg.rpt_sel;
        end

        do_exec = frame_end && core_reg.state == ST_IDLE
            && (new_data || core_reg.rpt_valid);

        case (core_reg.state)
            ST_LOAD: begin
                for (int ch = 0; ch < CHANNELS; ch++) begin
                    core_next.wiper_position_reg[ch] =
                        core_reg.nonvolatile_store[ch];
                end
                core_next.state = ST_IDLE;
            end
            ST_IDLE: begin
                core_next.state = ST_IDLE;
            end
            ST_PROG: begin
                if (core_reg.prog_cnt <= PROG_CNT_W'(1)) begin
                    core_next.state = ST_IDLE;
                end else begin
                    core_next.prog_cnt = core_reg.prog_cnt
                        - PROG_CNT_W'(1);
                end
            end
            default: begin
                core_next.state = ST_IDLE;
            end
        endcase

        if (do_exec) begin
            core_next.rb_en = 1'b0;
            if (new_data) begin
                core_next.rpt_valid = op[2];
                core_next.rpt_cmd = op;
                core_next.rpt_sel = sel;
            end
            case (op)
                CMD_NOP: begin
                    core_next.rb_en = 1'b0;
                end
                CMD_RESTORE_ONE: begin
                    core_next.wiper_position_reg[sel] =
                        core_reg.nonvolatile_store[sel];
                end
                CMD_SAVE: begin
                    if (wp_free) begin
                        core_next.nonvolatile_store[sel] =
                            core_reg.wiper_position_reg[sel];
                        core_next.state = ST_PROG;
                        core_next.prog_cnt = PROG_LOAD;
                    end
                end
                CMD_STORE_USER: begin
                    if (wp_free) begin
                        core_next.nonvolatile_store[addr] = dat;
                        core_next.state = ST_PROG;
                        core_next.prog_cnt = PROG_LOAD;
                    end
                end
                CMD_RESTORE_ALL: begin
                    for (int ch = 0; ch < CHANNELS; ch++) begin
                        core_next.wiper_position_reg[ch] =
                            core_reg.nonvolatile_store[ch];
                    end
                end
                CMD_READ_NV: begin
                    core_next.rb_en = 1'b1;
                    core_next.rb_byte = core_reg.nonvolatile_store[addr];
                end
                CMD_READ_WIPER: begin
                    core_next.rb_en = 1'b1;
                    core_next.rb_byte = core_reg.wiper_position_reg[sel];
                end
                CMD_WRITE_WIPER: begin
                    if (wp_free) begin
                        core_next.wiper_position_reg[sel] = dat;
                    end
                end
                default: begin
                    // Odd codes of the step group act on every channel.
                    for (int ch = 0; ch < CHANNELS; ch++) begin
                        if (wp_free && (op[0] || 1'(ch) == sel)) begin
                            core_next.wiper_position_reg[ch] = step_value(
                                op, core_reg.wiper_position_reg[ch]);
                        end
                    end
                end
            endcase
        end

        // The preset pin overrides the wiper update of any command in the same cycle.
        if (!core_reg.pr_s2) begin
            core_next.wiper_position_reg = {CHANNELS{MIDSCALE}};
        end else if (!core_reg.pr_prev) begin
            for (int ch = 0; ch < CHANNELS; ch++) begin
                core_next.wiper_position_reg[ch] =
                    core_reg.nonvolatile_store[ch];
            end
        end
    end

    always_ff @(posedge i_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            core_reg <= CORE_RST;
        end else begin
            core_reg <= core_next;
        end
    end

    // Ready is pulled low while a program cycle, power-up load or preset
    // is in progress, and released to signal completion.
    assign o_rdy_oe_n = core_reg.state == ST_IDLE
        && core_reg.pr_s2 && core_reg.pr_prev;
    assign o_rdy_out = 1'b0;
    assign o_sdo_out = 1'b0;
    assign o_wiper0 = core_reg.wiper_position_reg[0];
    assign o_wiper1 = core_reg.wiper_position_reg[1];
    assign lnk.rb_en = core_reg.rb_en;
    assign lnk.rb_byte = core_reg.rb_byte;
endmodule : dwsc_top

// file: sim/dwsc_top_checker.sv
// Port-level assertions for the dual wiper serial control block.
module dwsc_checker
    import dwsc_pkg::*;
#(
    parameter int unsigned PROG_CYCLES = SAVE_CYCLES
)
(
    input wire logic i_clk,
    input wire logic i_sys_rst,
    input wire logic i_sclk,
    input wire logic i_sdi,
    input wire logic i_cs_n,
    input wire logic i_preset_n,
    input wire logic i_wp_n,
    input wire logic o_sdo_out,
    input wire logic o_sdo_oe_n,
    input wire logic o_rdy_out,
    input wire logic o_rdy_oe_n,
    input wire logic [7:0] o_wiper0,
    input wire logic [7:0] o_wiper1
);
    timeunit 1ns;
    timeprecision 100ps;
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_sys_rst);
    logic [31:0] busy_cnt_reg;
    always_ff @(posedge i_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            busy_cnt_reg <= 32'h0;
        end else if (o_rdy_oe_n || !i_preset_n) begin
            busy_cnt_reg <= 32'h0;
        end else begin
            busy_cnt_reg <= busy_cnt_reg + 32'h1;
        end
    end
    a_sdo_released: assert property (i_cs_n |-> o_sdo_oe_n)
        else $error("sdo driven while deselected");
    a_drive_low: assert property (!o_sdo_out && !o_rdy_out)
        else $error("open-drain value not low");
    a_preset_mid: assert property (!i_preset_n [*5] |->
        o_wiper0 == MIDSCALE && o_wiper1 == MIDSCALE)
        else $error("wipers not midscale under preset");
    a_preset_busy: assert property (!i_preset_n [*5] |-> !o_rdy_oe_n)
        else $error("ready released under preset");
    a_cs_quiet: assert property ((!i_cs_n && i_preset_n) [*6] |->
        $stable(o_wiper0) && $stable(o_wiper1))
        else $error("wiper moved while selected");
    a_exec_delay: assert property ($rose(i_cs_n) && i_preset_n |->
        ($stable(o_wiper0) && $stable(o_wiper1)) [*2])
        else $error("wiper moved before word settled");
    a_prog_len: assert property (busy_cnt_reg <= PROG_CYCLES + 2)
        else $error("program cycle too long");
    a_prog_min: assert property ($fell(o_rdy_oe_n) && i_preset_n |->
        !o_rdy_oe_n [*8])
        else $error("program cycle too short");
endmodule : dwsc_checker

bind dwsc_top dwsc_checker #(.PROG_CYCLES(PROG_CYCLES)) i_chk (
    .i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_sclk(i_sclk), .i_sdi(i_sdi),
    .i_cs_n(i_cs_n), .i_preset_n(i_preset_n), .i_wp_n(i_wp_n),
    .o_sdo_out(o_sdo_out), .o_sdo_oe_n(o_sdo_oe_n), .o_rdy_out(o_rdy_out),
    .o_rdy_oe_n(o_rdy_oe_n), .o_wiper0(o_wiper0), .o_wiper1(o_wiper1));

// file: sim/dwsc_host_model.sv
// Serial master that frames command words for the wiper block.
module dwsc_host_model (
    output logic o_sclk,
    output logic o_sdi,
    output logic o_cs_n,
    input wire logic i_sdo
);
    timeunit 1ns;
    timeprecision 100ps;
    initial begin
        o_sclk = 1'b0;
        o_sdi = 1'b0;
        o_cs_n = 1'b1;
    end
    // The clock rests at its idle level outside frames.
    task automatic frame(input logic [31:0] w, input int n, input bit cpol,
                         output logic [31:0] rx);
        rx = 32'h0;
        o_sclk = cpol;
        #3 o_cs_n = 1'b0;
        for (int i = n - 1; i >= 0; i--) begin
            #3 o_sclk = 1'b0;
            o_sdi = w[i];
            #3 o_sclk = 1'b1;
            rx = {rx[30:0], i_sdo};
        end
        if (n == 0) #30;
        #3 o_sclk = cpol;
        o_cs_n = 1'b1;
        o_sdi = ~o_sdi;
    endtask : frame
endmodule : dwsc_host_model

// file: sim/dwsc_top_tb.sv
// Self-checking bench for the dual wiper serial control block.
module dwsc_top_tb;
    timeunit 1ns;
    timeprecision 100ps;
    logic clk = 1'b0;
    logic rst = 1'b0;
    logic preset_n = 1'b1;
    logic wp_n = 1'b1;
    logic sclk, sdi, cs_n, sdo_out, sdo_oe_n, rdy_out, rdy_oe_n, sdo_pin;
    logic [7:0] wiper0, wiper1;
    logic [15:0] prev;
    int mismatches = 0;
    int n_tests = 0;
    int seed = 1372;
    int wip[2], nv[16];
    int rep, rep_a, rb, d, c;
    bit busy, rb_valid, sdo_ok;

    always #5 clk = ~clk;
    assign sdo_pin = sdo_oe_n ? 1'b1 : sdo_out;

    dwsc_top #(.PROG_CYCLES(40)) i_dut (
        .i_clk(clk), .i_sys_rst(rst), .i_sclk(sclk), .i_sdi(sdi),
        .i_cs_n(cs_n), .i_preset_n(preset_n), .i_wp_n(wp_n),
        .o_sdo_out(sdo_out), .o_sdo_oe_n(sdo_oe_n), .o_rdy_out(rdy_out),
        .o_rdy_oe_n(rdy_oe_n), .o_wiper0(wiper0), .o_wiper1(wiper1));
    dwsc_host_model i_host (.o_sclk(sclk), .o_sdi(sdi), .o_cs_n(cs_n),
        .i_sdo(sdo_pin));

    task automatic chk(input string what, input logic [31:0] exp,
                       input logic [31:0] got);
        n_tests++;
        if (got !== exp) begin
            mismatches++;
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
        end
    endtask : chk

    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", n_tests, mismatches);
        if (mismatches == 0 && n_tests > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : tally_and_finish

    function automatic void step(input int s, input int a);
        for (int k = 0; k < 2; k++) begin
            if (k == a || s[0]) begin
                case ({s[3], s[1]})
                    2'h0: wip[k] = wip[k] / 2;
                    2'h1: wip[k] = (wip[k] > 0) ? wip[k] - 1 : 0;
                    2'h2: wip[k] = (wip[k] > 127) ? 255 : wip[k] * 2 + 1;
                    default: wip[k] = (wip[k] < 255) ? wip[k] + 1 : 255;
                endcase
            end
        end
    endfunction : step

    function automatic void exec(input logic [15:0] w);
        int k, a;
        k = w[15:12];
        a = w[8];
        rb_valid = 0;
        rep = w[14] ? k : -1;
        rep_a = a;
        if (!wp_n && (w[14] || k == 2 || k == 3 || k == 11)) return;
        case (k)
            1: wip[a] = nv[a];
            2: nv[a] = wip[a];
            3: nv[w[11:8]] = w[7:0];
            8: foreach (wip[j]) wip[j] = nv[j];
            9: rb = nv[w[11:8]];
            10: rb = wip[a];
            11: wip[a] = w[7:0];
            default: if (w[14]) step(k, a);
        endcase
        busy = (k == 2 || k == 3);
        rb_valid = (k == 9 || k == 10);
    endfunction : exec

    task automatic xfer(input logic [31:0] w, input int n, input bit cpol);
        logic [31:0] rx;
        logic [15:0] es;
        es = prev;
        if (rb_valid) es[7:0] = rb[7:0];
        @(negedge clk);
        i_host.frame(w, n, cpol, rx);
        if (n == 0) begin
            if (rep >= 0 && wp_n && !busy) step(rep, rep_a);
            sdo_ok = 0;
        end else if (busy) begin
            sdo_ok = 0;
        end else begin
            if (sdo_ok && n == 16 && !cpol) chk("sdo", es, rx);
            if (sdo_ok && n == 32) chk("chain", {es, w[31:16]}, rx);
            exec(w[15:0]);
            prev = w[15:0];
            sdo_ok = 1;
        end
        repeat (8) @(negedge clk);
        chk("wiper0", wip[0], wiper0);
        chk("wiper1", wip[1], wiper1);
    endtask : xfer

    task automatic wait_rdy;
        int k;
        k = 0;
        while (rdy_oe_n !== 1'b1 && k < 200) begin
            @(negedge clk);
            k++;
        end
        if (k >= 200) begin
            $display("MISMATCH ready expected 1 seen %b", rdy_oe_n);
            mismatches++;
            tally_and_finish;
        end
        busy = 0;
    endtask : wait_rdy

    initial begin
        // A real rising edge of reset also clears the serial clock side.
        #1 rst = 1'b1;
        foreach (nv[j]) nv[j] = 128;
        foreach (wip[j]) wip[j] = 128;
        rep = -1;
        repeat (2) @(negedge clk);
        rst = 1'b0;
        repeat (2) @(negedge clk);
        chk("reset0", 8'h80, wiper0);
        chk("reset1", 8'h80, wiper1);
        d = $random(seed);
        xfer({16'h0, 8'hb0, d[7:0]}, 16, 0);
        xfer(32'h2000, 16, 0);
        chk("busy", 1'b0, rdy_oe_n);
        xfer(32'hb155, 16, 0);
        wait_rdy;
        xfer(32'hb180, 16, 0);
        xfer(32'h2100, 16, 0);
        wait_rdy;
        xfer({16'h0, 8'h37, d[15:8]}, 16, 0);
        wait_rdy;
        xfer(32'h9700, 16, 0);
        xfer(32'ha100, 16, 0);
        xfer(32'h9000, 16, 0);
        for (int i = 0; i < 8; i++) begin
            d = $random(seed);
            c = (i < 4) ? i + 4 : i + 8;
            xfer({16'h0, 8'hb0, d[7:0]}, 16, 0);
            xfer({16'h0, c[3:0], 3'h0, d[8], d[15:8]}, 16, 0);
            xfer(32'h0, 0, 0);
        end
        xfer({16'h0, 8'hb1, d[23:16]}, 16, 1);
        xfer(32'hef00, 16, 1);
        xfer({16'hb0c3, 16'hb13c}, 32, 0);
        preset_n = 1'b0;
        repeat (6) @(negedge clk);
        chk("preset0", 8'h80, wiper0);
        chk("preset1", 8'h80, wiper1);
        chk("preset_busy", 1'b0, rdy_oe_n);
        preset_n = 1'b1;
        foreach (wip[j]) wip[j] = nv[j];
        repeat (6) @(negedge clk);
        chk("reload0", wip[0], wiper0);
        chk("reload1", wip[1], wiper1);
        chk("reload_rdy", 1'b1, rdy_oe_n);
        xfer(32'hb07e, 16, 0);
        wp_n = 1'b0;
        xfer(32'hb0aa, 16, 0);
        xfer(32'hf000, 16, 0);
        xfer(32'h2000, 16, 0);
        xfer(32'h1000, 16, 0);
        xfer(32'h8000, 16, 0);
        xfer(32'h0, 16, 0);
        wp_n = 1'b1;
        xfer(32'h0, 16, 0);
        tally_and_finish;
    end
endmodule : dwsc_top_tb
